/* core/vic_pkg.sv */
// Constants and register map for the video input capture unit
//
// Contract
// - Hsync, vsync and field id each have their own read/write polarity bit.
// - Hsync period and vsync period are measured and read as 12-bit values.
// - One read-only flag shows that dedicated hsync and vsync activity is seen.
// - One read-only flag shows interlaced versus progressive input.
// - Only the programmed rectangle is captured, placed at the programmed origin.
// - Pixels are stored 16 bits each: 8-bit luma plus alternating Cb/Cr byte.
// - Interlaced input: two consecutive fields interleave into one stored frame.
// - Single-frame mode writes exactly one frame then stops by itself.
// - Continuous mode rewrites frames from the start address until forced stop.
// - Pixel and line thinning shrink the stored image by the selected ratio.
// - Frame thinning acts only in continuous mode, skipping frames between captures.
// - Writing one to trigger starts capture; writing zero stops it at once.
// - Trigger reads one while capturing, zero when done or stopped.
// - Mode bit: zero selects single-frame, one selects continuous capture.
// - Horizontal start, vertical start and horizontal size are 12-bit read/write.
// - Pixel and line thinning are 3 bits; codes 0 to 4 give 1/1 to 1/16.
// - Frame thinning is 4 bits; code n keeps one frame in n+1.
// - Destination X is 12 bits of 8 pixels; Y is 12 bits of lines.
// - Format select: 00 embedded 8-bit, 01 8-bit separate sync, 10 16-bit.
// - With dedicated syncs idle, syncs come from embedded timing codes.
// - Without field id, scan type comes from hsync/vsync phase; field made internally.
package vic_pkg;
  localparam int ADDR_W = 8;
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_HPERIOD = 8'h04;
  localparam logic [7:0] OFS_VPERIOD = 8'h08;
  localparam logic [7:0] OFS_STATUS = 8'h0c;
  localparam logic [7:0] OFS_HSTART = 8'h10;
  localparam logic [7:0] OFS_VSTART = 8'h14;
  localparam logic [7:0] OFS_HSIZE = 8'h18;
  localparam logic [7:0] OFS_VSIZE = 8'h1c;
  localparam logic [7:0] OFS_SKIP = 8'h20;
  localparam logic [7:0] OFS_DESTX = 8'h24;
  localparam logic [7:0] OFS_DESTY = 8'h28;
  // Control register fields
  localparam int CTRL_TRIG = 0;
  localparam int CTRL_MODE = 1;
  localparam int CTRL_FMT_LO = 2;
  localparam int CTRL_PORT = 4;
  localparam int CTRL_HPOL = 5;
  localparam int CTRL_VPOL = 6;
  localparam int CTRL_FPOL = 7;
  // Status register fields
  localparam int STAT_SYNC = 0;
  localparam int STAT_SCAN = 1;
  // Thinning register fields
  localparam int SKIP_H_LO = 0;
  localparam int SKIP_V_LO = 3;
  localparam int SKIP_F_LO = 6;
  // Input format codes
  localparam logic [1:0] FMT_EMBED = 2'h0;
  localparam logic [1:0] FMT_SEP8 = 2'h1;
  localparam logic [1:0] FMT_WIDE16 = 2'h2;
  // Reset values
  localparam logic [11:0] RST_SIZE = 12'h000;
  localparam logic [11:0] RST_POS = 12'h000;
  // Sync idle limit in pixel clocks (hsync) or lines (vsync)
  localparam logic [11:0] IDLE_MAX = 12'hfff;
  localparam logic [1:0] FID_IDLE_MAX = 2'h3;
  typedef enum logic [1:0] {ST_IDLE, ST_WAIT, ST_GRAB} vic_state_t;
endpackage

/* core/vic_capture.sv */
// Video input capture unit: sync handling, measurement and rectangle capture
`timescale 1ns/1ps
`default_nettype none
module vic_capture #(
  parameter int YUNIT_SHIFT = 0
) (
  input wire logic clock,
  input wire logic nrst,
  input wire logic [7:0] regAddr,
  input wire logic [31:0] regWdata,
  input wire logic regWrite,
  input wire logic regRead,
  output logic [31:0] regRdata,
  input wire logic in_pixel_clock,
  input wire logic in_hsync,
  input wire logic in_vsync,
  input wire logic in_field_id,
  input wire logic [7:0] luma_port,
  input wire logic [7:0] chroma_port,
  output logic wrValid,
  output logic [14:0] wrX,
  output logic [11:0] wrY,
  output logic [15:0] wrData
);
  // Registers
  logic trig, capture_mode_select, embedded_port_select;
  logic hsync_polarity_select, vsync_polarity_select, field_id_polarity_select;
  logic [1:0] input_format_select;
  logic [11:0] active_h_start, active_v_start, active_h_size, active_v_size;
  logic [2:0] h_pixel_skip_rate, v_line_skip_rate;
  logic [3:0] frame_skip_rate;
  logic [11:0] dest_x_address, dest_y_address;
  logic [11:0] hsync_period_measured, vsync_period_measured;
  logic sync_present_flag, scan_type_flag;
  vic_pkg::vic_state_t state;
  logic [3:0] skipCnt;

  // Pin synchronisers: stage one is read only by stage two
  logic [19:0] pinMeta, pinSync;
  logic pclkPrev;
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      pinMeta <= '0;
      pinSync <= '0;
      pclkPrev <= 1'b0;
    end else begin
      pinMeta <= {in_pixel_clock, in_hsync, in_vsync, in_field_id, luma_port, chroma_port};
      pinSync <= pinMeta;
      pclkPrev <= pinSync[19];
    end
  end
  logic pclkRise;
  logic hsIn, vsIn, fidIn;
  logic [7:0] lumaIn, chromaIn;
  assign pclkRise = pinSync[19] & ~pclkPrev;
  assign hsIn = pinSync[18] ^ hsync_polarity_select;
  assign vsIn = pinSync[17] ^ vsync_polarity_select;
  assign fidIn = pinSync[16] ^ field_id_polarity_select;
  assign lumaIn = pinSync[15:8];
  assign chromaIn = pinSync[7:0];

  // Dedicated sync edges, sampled at each pixel clock rise
  logic hsPrev, vsPrev, fidPrev;
  logic extHsEv, extVsEv;
  assign extHsEv = pclkRise & hsIn & ~hsPrev;
  assign extVsEv = pclkRise & vsIn & ~vsPrev;

  // Embedded timing reference decode on the selected port
  logic [23:0] codeHist;
  logic [7:0] emByte;
  logic emFlag, emV, codeHit;
  assign emByte = embedded_port_select ? chromaIn : lumaIn;
  assign codeHit = pclkRise && codeHist == 24'hff0000;

  // Activity and period measurement
  logic [11:0] hIdle, vIdle, hClk, lineCnt;
  logic [1:0] fidIdle;
  logic useEmbed, wide;
  logic hsEv, vsEv, fieldNow, curField, halfLine;
  assign useEmbed = input_format_select == vic_pkg::FMT_EMBED || !sync_present_flag;
  assign wide = input_format_select == vic_pkg::FMT_WIDE16 && !useEmbed;
  assign hsEv = useEmbed ? codeHit && emByte[4] : extHsEv;
  assign vsEv = useEmbed ? codeHit && emByte[5] && !emV : extVsEv;
  // A vsync that lands on an hsync starts a line, so it is never the second field
  assign halfLine = !hsEv && hClk >= {1'b0, hsync_period_measured[11:1]};
  always_comb begin
    if (useEmbed) begin
      fieldNow = emByte[6];
    end else if (fidIdle != vic_pkg::FID_IDLE_MAX) begin
      fieldNow = fidIn;
    end else begin
      fieldNow = halfLine;
    end
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      hsPrev <= 1'b0;
      vsPrev <= 1'b0;
      fidPrev <= 1'b0;
      codeHist <= '0;
      emV <= 1'b0;
      emFlag <= 1'b0;
    end else if (pclkRise) begin
      hsPrev <= hsIn;
      vsPrev <= vsIn;
      fidPrev <= fidIn;
      codeHist <= {codeHist[15:0], emByte};
      emFlag <= codeHit;
      if (codeHit && emByte[4]) begin
        emV <= emByte[5];
      end
    end
  end

  // Idle timers on the dedicated syncs decide sync presence
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      hIdle <= vic_pkg::IDLE_MAX;
      vIdle <= vic_pkg::IDLE_MAX;
      fidIdle <= vic_pkg::FID_IDLE_MAX;
    end else begin
      if (extHsEv) begin
        hIdle <= '0;
      end else if (pclkRise && hIdle != vic_pkg::IDLE_MAX) begin
        hIdle <= hIdle + 12'h001;
      end
      if (extVsEv) begin
        vIdle <= '0;
      end else if (extHsEv && vIdle != vic_pkg::IDLE_MAX) begin
        vIdle <= vIdle + 12'h001;
      end
      if (pclkRise && fidIn != fidPrev) begin
        fidIdle <= '0;
      end else if (extVsEv && fidIdle != vic_pkg::FID_IDLE_MAX) begin
        fidIdle <= fidIdle + 2'h1;
      end
    end
  end
  assign sync_present_flag = hIdle != vic_pkg::IDLE_MAX && vIdle != vic_pkg::IDLE_MAX;

  // Periods: pixel clocks per line and lines per vsync, saturating at 12 bits
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      hClk <= '0;
      lineCnt <= '0;
      hsync_period_measured <= '0;
      vsync_period_measured <= '0;
      curField <= 1'b0;
      scan_type_flag <= 1'b0;
    end else begin
      if (hsEv) begin
        hsync_period_measured <= hClk;
        hClk <= 12'h001;
      end else if (pclkRise && hClk != vic_pkg::IDLE_MAX) begin
        hClk <= hClk + 12'h001;
      end
      if (vsEv) begin
        vsync_period_measured <= (hsEv && lineCnt != vic_pkg::IDLE_MAX) ? lineCnt + 12'h001 : lineCnt;
        lineCnt <= '0;
        curField <= fieldNow;
        scan_type_flag <= fieldNow != curField;
      end else if (hsEv && lineCnt != vic_pkg::IDLE_MAX) begin
        lineCnt <= lineCnt + 12'h001;
      end
    end
  end

  // Pixel assembly: 8-bit streams carry chroma then luma per pixel
  logic bytePhase;
  logic [7:0] chromaHold;
  logic [11:0] pixCnt;
  logic pixStrobe;
  logic [15:0] pixWord;
  assign pixStrobe = pclkRise && (wide || bytePhase);
  assign pixWord = wide ? {lumaIn, chromaIn} : {useEmbed ? emByte : lumaIn, chromaHold};
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      bytePhase <= 1'b0;
      chromaHold <= '0;
      pixCnt <= '0;
    end else if (hsEv) begin
      bytePhase <= 1'b0;
      pixCnt <= '0;
    end else if (pclkRise) begin
      bytePhase <= ~bytePhase;
      if (!bytePhase) begin
        chromaHold <= useEmbed ? emByte : lumaIn;
      end
      if (pixStrobe) begin
        pixCnt <= pixCnt + 12'h001;
      end
    end
  end

  // Thinning mask: codes above four act as 1/16
  function automatic logic [3:0] thinMask(input logic [2:0] code);
    thinMask = code > 3'h4 ? 4'hf : 4'((5'h01 << code) - 5'h01);
  endfunction
  function automatic logic [2:0] thinShift(input logic [2:0] code);
    thinShift = code > 3'h4 ? 3'h4 : code;
  endfunction

  logic [11:0] hOff, vOff, col, row;
  logic inRect, pixAccept, frameEdge;
  assign hOff = pixCnt - active_h_start;
  assign vOff = lineCnt - active_v_start;
  assign inRect = pixCnt >= active_h_start && hOff < active_h_size
    && lineCnt >= active_v_start && vOff < active_v_size;
  assign pixAccept = pixStrobe && state == vic_pkg::ST_GRAB && inRect
    && (hOff[3:0] & thinMask(h_pixel_skip_rate)) == 4'h0
    && (vOff[3:0] & thinMask(v_line_skip_rate)) == 4'h0;
  assign col = hOff >> thinShift(h_pixel_skip_rate);
  assign row = vOff >> thinShift(v_line_skip_rate);
  // Interlaced frames begin at the first field only, so both fields share one frame
  assign frameEdge = vsEv && (!scan_type_flag || !fieldNow);

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      wrValid <= 1'b0;
      wrX <= '0;
      wrY <= '0;
      wrData <= '0;
    end else begin
      wrValid <= pixAccept;
      if (pixAccept) begin
        wrX <= {dest_x_address, 3'h0} + 15'(col);
        wrY <= scan_type_flag
          ? 12'((dest_y_address << YUNIT_SHIFT) + {row[10:0], curField})
          : 12'((dest_y_address << YUNIT_SHIFT) + row);
        wrData <= pixWord;
      end
    end
  end

  // Capture sequencing; a control write takes priority over a frame edge
  logic ctrlWr;
  assign ctrlWr = regWrite && regAddr == vic_pkg::OFS_CTRL;
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      state <= vic_pkg::ST_IDLE;
      skipCnt <= '0;
    end else if (ctrlWr) begin
      state <= regWdata[vic_pkg::CTRL_TRIG] ? vic_pkg::ST_WAIT : vic_pkg::ST_IDLE;
      skipCnt <= '0;
    end else if (frameEdge) begin
      unique case (state)
        vic_pkg::ST_IDLE: begin
          state <= vic_pkg::ST_IDLE;
        end
        vic_pkg::ST_WAIT: begin
          if (skipCnt == 4'h0) begin
            state <= vic_pkg::ST_GRAB;
          end else begin
            skipCnt <= skipCnt - 4'h1;
          end
        end
        vic_pkg::ST_GRAB: begin
          if (!capture_mode_select) begin
            state <= vic_pkg::ST_IDLE;
          end else if (frame_skip_rate != 4'h0) begin
            state <= vic_pkg::ST_WAIT;
            skipCnt <= frame_skip_rate - 4'h1;
          end else begin
            state <= vic_pkg::ST_GRAB;
          end
        end
      endcase
    end
  end
  assign trig = state != vic_pkg::ST_IDLE;

  // Register writes
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      capture_mode_select <= 1'b0;
      input_format_select <= vic_pkg::FMT_EMBED;
      embedded_port_select <= 1'b0;
      hsync_polarity_select <= 1'b0;
      vsync_polarity_select <= 1'b0;
      field_id_polarity_select <= 1'b0;
      active_h_start <= vic_pkg::RST_POS;
      active_v_start <= vic_pkg::RST_POS;
      active_h_size <= vic_pkg::RST_SIZE;
      active_v_size <= vic_pkg::RST_SIZE;
      h_pixel_skip_rate <= '0;
      v_line_skip_rate <= '0;
      frame_skip_rate <= '0;
      dest_x_address <= vic_pkg::RST_POS;
      dest_y_address <= vic_pkg::RST_POS;
    end else if (regWrite) begin
      unique case (regAddr)
        vic_pkg::OFS_CTRL: begin
          capture_mode_select <= regWdata[vic_pkg::CTRL_MODE];
          input_format_select <= regWdata[vic_pkg::CTRL_FMT_LO +: 2];
          embedded_port_select <= regWdata[vic_pkg::CTRL_PORT];
          hsync_polarity_select <= regWdata[vic_pkg::CTRL_HPOL];
          vsync_polarity_select <= regWdata[vic_pkg::CTRL_VPOL];
          field_id_polarity_select <= regWdata[vic_pkg::CTRL_FPOL];
        end
        vic_pkg::OFS_HSTART: active_h_start <= regWdata[11:0];
        vic_pkg::OFS_VSTART: active_v_start <= regWdata[11:0];
        vic_pkg::OFS_HSIZE: active_h_size <= regWdata[11:0];
        vic_pkg::OFS_VSIZE: active_v_size <= regWdata[11:0];
        vic_pkg::OFS_SKIP: begin
          h_pixel_skip_rate <= regWdata[vic_pkg::SKIP_H_LO +: 3];
          v_line_skip_rate <= regWdata[vic_pkg::SKIP_V_LO +: 3];
          frame_skip_rate <= regWdata[vic_pkg::SKIP_F_LO +: 4];
        end
        vic_pkg::OFS_DESTX: dest_x_address <= regWdata[11:0];
        vic_pkg::OFS_DESTY: dest_y_address <= regWdata[11:0];
        default: begin
        end
      endcase
    end
  end

  // Register reads, data valid the cycle after the strobe; unmapped reads zero
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      regRdata <= '0;
    end else if (regRead) begin
      unique case (regAddr)
        vic_pkg::OFS_CTRL: regRdata <= 32'({field_id_polarity_select, vsync_polarity_select,
          hsync_polarity_select, embedded_port_select, input_format_select,
          capture_mode_select, trig});
        vic_pkg::OFS_HPERIOD: regRdata <= 32'(hsync_period_measured);
        vic_pkg::OFS_VPERIOD: regRdata <= 32'(vsync_period_measured);
        vic_pkg::OFS_STATUS: regRdata <= 32'({scan_type_flag, sync_present_flag});
        vic_pkg::OFS_HSTART: regRdata <= 32'(active_h_start);
        vic_pkg::OFS_VSTART: regRdata <= 32'(active_v_start);
        vic_pkg::OFS_HSIZE: regRdata <= 32'(active_h_size);
        vic_pkg::OFS_VSIZE: regRdata <= 32'(active_v_size);
        vic_pkg::OFS_SKIP: regRdata <= 32'({frame_skip_rate, v_line_skip_rate,
          h_pixel_skip_rate});
        vic_pkg::OFS_DESTX: regRdata <= 32'(dest_x_address);
        vic_pkg::OFS_DESTY: regRdata <= 32'(dest_y_address);
        default: regRdata <= '0;
      endcase
    end
  end

  // Checks
  default clocking cb @(posedge clock); endclocking
  default disable iff (!nrst);

  a_start_capture: assert property (ctrlWr && regWdata[0] |=> trig && state == vic_pkg::ST_WAIT)
    else $error("Trigger write of one did not start capture");
  a_force_stop: assert property (ctrlWr && !regWdata[0] |=> !trig ##1 !wrValid)
    else $error("Trigger write of zero did not stop capture");
  a_trig_readback: assert property (regRead && regAddr == vic_pkg::OFS_CTRL
    |=> regRdata[0] == $past(trig))
    else $error("Trigger read does not follow capture state");
  a_single_ends: assert property (state == vic_pkg::ST_GRAB && !capture_mode_select
    && frameEdge && !ctrlWr |=> state == vic_pkg::ST_IDLE)
    else $error("Single-frame capture did not stop after one frame");
  a_cont_repeats: assert property (state == vic_pkg::ST_GRAB && capture_mode_select
    && frame_skip_rate == 4'h0 && frameEdge && !ctrlWr |=> state == vic_pkg::ST_GRAB)
    else $error("Continuous capture left grabbing without a stop");
  a_skip_single: assert property (state == vic_pkg::ST_WAIT && !capture_mode_select
    |-> skipCnt == 4'h0)
    else $error("Frame thinning acted in single-frame mode");
  a_pixel_store: assert property (pixAccept |=> wrValid && wrData == $past(pixWord))
    else $error("Accepted pixel was not stored as one 16-bit word");
  a_only_grab: assert property (wrValid |-> $past(state) == vic_pkg::ST_GRAB)
    else $error("Buffer write outside a capture");
  a_hperiod: assert property (hsEv && hClk != vic_pkg::IDLE_MAX
    |=> hsync_period_measured == $past(hClk))
    else $error("Hsync period not latched at hsync");

  c_single_done: cover property (state == vic_pkg::ST_GRAB ##1 state == vic_pkg::ST_IDLE);
  c_cont_skip: cover property (state == vic_pkg::ST_GRAB ##1 state == vic_pkg::ST_WAIT);
  c_interlaced: cover property (scan_type_flag && wrValid);
  c_embedded: cover property (useEmbed && emFlag && pixAccept);
endmodule
`default_nettype wire

/* sim/vic_camera.sv */
// Camera model: 16-bit pixel source with separate syncs and a free-running pixel clock
`timescale 1ns/1ps
`default_nettype none
module vic_camera #(
  parameter int LINE_PIX = 20,
  parameter int FRAME_LINES = 8
) (
  input wire logic enable,
  output var logic pixClk,
  output var logic hsync,
  output var logic vsync,
  output var logic fieldId,
  output var logic [7:0] luma,
  output var logic [7:0] chroma
);
  int col;
  int row;
  // Steps stay on an 80 ns grid, which never meets a rising system clock edge
  initial begin
    col = 0;
    row = 0;
    forever begin
      if (enable) begin
        hsync = (col < 4);
        vsync = (row < 2);
        fieldId = 1'b0;
        // 16-bit source: Y on the luma port, C on the chroma port
        luma = 8'(col);
        chroma = 8'(row);
        // Rate is far above the guide; nothing here depends on buffer bandwidth
        #80 pixClk = 1'b1;
        #80 pixClk = 1'b0;
        col = (col == LINE_PIX - 1) ? 0 : col + 1;
        row = (col != 0) ? row : (row == FRAME_LINES - 1) ? 0 : row + 1;
      end else begin
        // Released pins fall to their pull levels
        pixClk = 1'b0;
        hsync = 1'b1;
        vsync = 1'b1;
        fieldId = 1'b1;
        luma = 8'hff;
        chroma = 8'hff;
        col = 0;
        row = 0;
        #80;
      end
    end
  end
endmodule
`default_nettype wire

/* sim/tb.sv */
// Testbench for the video input capture unit
`timescale 1ns/1ps
`default_nettype none
module tb;
  localparam int LPIX = 20;
  localparam int FLINES = 8;
  localparam int FRAME_CLK = LPIX * FLINES * 20;
  localparam logic [31:0] CTRL16 = 32'(vic_pkg::FMT_WIDE16) << vic_pkg::CTRL_FMT_LO;
  logic clock = 1'b0;
  logic nrst = 1'b0;
  logic [7:0] regAddr = 8'h00;
  logic [31:0] regWdata = 32'h0;
  logic regWrite = 1'b0;
  logic regRead = 1'b0;
  logic camEn = 1'b0;
  logic [31:0] regRdata;
  logic pixClk, hsync, vsync, fieldId, wrValid;
  logic [7:0] luma, chroma, firstL, firstR;
  logic [14:0] wrX;
  logic [11:0] wrY;
  logic [15:0] wrData;
  logic [14:0] baseX = 15'h0;
  logic [11:0] baseY = 12'h0;
  int error_cnt = 0;
  int n_checks = 0;
  int wrCnt = 0;
  int hStep = 1;
  int vStep = 1;
  int k0;
  longint stamps [$];

  always #4 clock = ~clock;

  vic_capture dut (.clock(clock), .nrst(nrst), .regAddr(regAddr), .regWdata(regWdata),
    .regWrite(regWrite), .regRead(regRead), .regRdata(regRdata), .in_pixel_clock(pixClk),
    .in_hsync(hsync), .in_vsync(vsync), .in_field_id(fieldId), .luma_port(luma),
    .chroma_port(chroma), .wrValid(wrValid), .wrX(wrX), .wrY(wrY), .wrData(wrData));

  vic_camera #(.LINE_PIX(LPIX), .FRAME_LINES(FLINES)) cam (.enable(camEn), .pixClk(pixClk),
    .hsync(hsync), .vsync(vsync), .fieldId(fieldId), .luma(luma), .chroma(chroma));

  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
    n_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    regAddr <= a;
    regWdata <= d;
    regWrite <= 1'b1;
    @(posedge clock);
    regWrite <= 1'b0;
  endtask

  task automatic reg_rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clock);
    regAddr <= a;
    regRead <= 1'b1;
    @(posedge clock);
    regRead <= 1'b0;
    #1;
    d = regRdata;
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp, input string what);
    logic [31:0] v;
    reg_rd(a, v);
    check(v, exp, what);
  endtask

  task automatic wr_rd(input logic [7:0] a, input logic [31:0] d, input logic [31:0] exp);
    reg_wr(a, d);
    rd_chk(a, exp, "register readback");
  endtask

  // Polls the trigger bit; a hang shows up as a mismatch instead of a stall
  task automatic wait_idle();
    logic [31:0] v;
    v = 32'h1;
    for (int k = 0; k < 400 && v[0] !== 1'b0; k++) begin
      repeat (50) @(posedge clock);
      reg_rd(vic_pkg::OFS_CTRL, v);
    end
    check({31'h0, v[0]}, 32'h0, "capture finished");
  endtask

  task automatic test_done();
    $display("checks %0d, mismatches %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // Data carry their own column and line, so thinning and placement show in each write
  always @(posedge clock) begin
    if (wrValid === 1'b1) begin
      if (wrCnt == 0) begin
        firstL = wrData[15:8];
        firstR = wrData[7:0];
      end
      if (wrX === baseX && wrY === baseY) begin
        stamps.push_back($time / 8);
      end
      check(32'(8'(wrData[15:8] - firstL)), (32'(wrX) - 32'(baseX)) * hStep, "column");
      check(32'(8'(wrData[7:0] - firstR)), (32'(wrY) - 32'(baseY)) * vStep, "line");
      wrCnt++;
    end
  end

  initial begin
    #720_000;
    error_cnt++;
    $display("wrong value at %0t: watchdog expired", $time);
    test_done();
  end

  initial begin
    repeat (16) @(posedge clock);
    nrst <= 1'b1;
    for (int a = 0; a < 64; a += 4) begin
      rd_chk(8'(a), 32'h0, "reset value");
    end
    wr_rd(vic_pkg::OFS_CTRL, 32'hffff_fff6, 32'hf6);
    wr_rd(vic_pkg::OFS_HSTART, 32'hffff_ffff, 32'hfff);
    wr_rd(vic_pkg::OFS_VSTART, 32'h123, 32'h123);
    wr_rd(vic_pkg::OFS_HSIZE, 32'habc, 32'habc);
    wr_rd(vic_pkg::OFS_VSIZE, 32'hffff_ffff, 32'hfff);
    wr_rd(vic_pkg::OFS_SKIP, 32'hffff_ffff, 32'h3ff);
    wr_rd(vic_pkg::OFS_DESTX, 32'hffff_ffff, 32'hfff);
    wr_rd(vic_pkg::OFS_DESTY, 32'ha5a, 32'ha5a);
    wr_rd(vic_pkg::OFS_HPERIOD, 32'hfff, 32'h0);
    wr_rd(vic_pkg::OFS_STATUS, 32'h3, 32'h0);
    wr_rd(8'h3c, 32'hffff_ffff, 32'h0);
    for (int f = 0; f < 3; f++) begin
      wr_rd(vic_pkg::OFS_CTRL, 32'(f) << vic_pkg::CTRL_FMT_LO, 32'(f) << 2);
    end
    $display("register test done");
    reg_wr(vic_pkg::OFS_CTRL, CTRL16);
    camEn <= 1'b1;
    repeat (3 * FRAME_CLK) @(posedge clock);
    rd_chk(vic_pkg::OFS_HPERIOD, LPIX, "hsync period");
    rd_chk(vic_pkg::OFS_VPERIOD, FLINES, "vsync period");
    rd_chk(vic_pkg::OFS_STATUS, 32'h1, "sync present, progressive");
    $display("measurement test done");
    reg_wr(vic_pkg::OFS_HSTART, 32'h2);
    reg_wr(vic_pkg::OFS_VSTART, 32'h1);
    reg_wr(vic_pkg::OFS_HSIZE, 32'd16);
    reg_wr(vic_pkg::OFS_VSIZE, 32'd6);
    reg_wr(vic_pkg::OFS_DESTX, 32'h3);
    reg_wr(vic_pkg::OFS_DESTY, 32'h5);
    baseX = 15'd24;
    baseY = 12'd5;
    // Frame thinning at its largest is set too, and must not delay single-frame mode
    for (int c = 0; c < 5; c++) begin
      hStep = 1 << c;
      vStep = 1 << c;
      wrCnt = 0;
      stamps.delete();
      reg_wr(vic_pkg::OFS_SKIP, (32'(c) << vic_pkg::SKIP_V_LO) | 32'(c) | 32'h3c0);
      reg_wr(vic_pkg::OFS_CTRL, CTRL16 | 32'h1);
      rd_chk(vic_pkg::OFS_CTRL, CTRL16 | 32'h1, "busy after start");
      wait_idle();
      if (c == 0) begin
        repeat (FRAME_CLK) @(posedge clock);
        check(32'(firstL), 32'h3, "first column");
        check(32'(firstR), 32'h1, "first line");
      end
      check(wrCnt, ((15 + hStep) / hStep) * ((5 + vStep) / vStep), "pixel count");
      check(stamps.size(), 1, "frames written");
      $display("single capture with thinning code %0d done", c);
    end
    hStep = 1;
    vStep = 1;
    wrCnt = 0;
    stamps.delete();
    reg_wr(vic_pkg::OFS_SKIP, 32'h1 << vic_pkg::SKIP_F_LO);
    reg_wr(vic_pkg::OFS_CTRL, CTRL16 | 32'h3);
    for (int k = 0; k < 5 * FRAME_CLK && stamps.size() < 2; k++) begin
      @(posedge clock);
    end
    check(32'(stamps.size()), 32'h2, "continuous frames");
    check(32'(stamps[1] - stamps[0]), 2 * FRAME_CLK, "frame interval");
    reg_wr(vic_pkg::OFS_CTRL, CTRL16 | 32'h2);
    rd_chk(vic_pkg::OFS_CTRL, CTRL16 | 32'h2, "forced stop");
    k0 = wrCnt;
    repeat (FRAME_CLK) @(posedge clock);
    check(wrCnt, k0, "writes after stop");
    $display("continuous capture test done");
    test_done();
  end
endmodule
`default_nettype wire
